// ### pkg/dcf_pkg.sv
// constants and types for the dual-port fifo with port flags
package dcf_pkg;

    // ---------------------------------------------------------------
    // array geometry
    // ---------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int ADDR_W = 11;
    localparam int PTR_W = 12;
    localparam int OFS_W = 11;
    localparam logic [11:0] FIFO_DEPTH = 12'h800;

    // ---------------------------------------------------------------
    // offset programming
    // ---------------------------------------------------------------
    localparam int SER_BITS = 22;
    localparam int SER_CNT_W = 5;
    localparam logic [4:0] SER_LAST = 5'h15;
    localparam logic [10:0] OFS_PRESET_SMALL = 11'h008;
    localparam logic [10:0] OFS_PRESET_LARGE = 11'h040;
    localparam logic [10:0] OFS_RESET = 11'h000;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [35:0] DATA_RESET = 36'h000000000;

    // ---------------------------------------------------------------
    // offset-select pair {select1, select0} at reset release
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        DCF_MODE_PARALLEL = 2'h0,
        DCF_MODE_PRESET8 = 2'h1,
        DCF_MODE_PRESET64 = 2'h2,
        DCF_MODE_SERIAL = 2'h3
    } dcf_mode_t;

    // ---------------------------------------------------------------
    // programming and run states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        DCF_ST_IDLE = 3'h0,
        DCF_ST_WAIT = 3'h1,
        DCF_ST_PAR_Y = 3'h2,
        DCF_ST_PAR_X = 3'h3,
        DCF_ST_SERIAL = 3'h4,
        DCF_ST_SER_DONE = 3'h5,
        DCF_ST_RUN = 3'h6
    } dcf_state_t;

endpackage

// ### rtl/dcf_fifo.sv
// dual-port fifo with mailboxes, offset programming and port flags
`timescale 1ns/100ps

// Operation
// - both offset-selects low at reset release select parallel offset loading via port A.
// - after parallel-mode reset, input-ready rises after two port A clock edges.
// - first two fifo writes load almost-full then almost-empty offset, later writes store data.
// - offsets take the low port A bits, highest bit most significant.
// - almost-empty uses its offset, almost-full uses its offset as threshold.
// - both offset-selects high at reset release select serial offset loading.
// - serial mode shifts one data bit per port A edge with serial enable low.
// - serial load takes 22 bits, almost-full MSB first, almost-empty LSB last.
// - in serial mode input-ready stays low, rises the edge after the last bit.
// - port A bus drives only when select and write-not-read are both low.
// - fifo write stores port A bus when selected, enabled, non-mailbox and input-ready.
// - port B bus drives only when select is low and read-not-write high.
// - fifo read advances next word when selected, enabled, non-mailbox and output-ready.
// - port A mailbox read drives the B-to-A mailbox and sets its flag high.
// - port B read drives A-to-B mailbox or output register; mailbox read sets flag high.
// - with output-ready low, the edge raising it also loads the next word.
// - input-ready and almost-full pass two flip-flop stages, output-ready and almost-empty three, in their own port domain.
// - output-ready low keeps the previous word and ignores read attempts.
// - read pointer advances per word taken; new word shows on third port B edge.
// - input-ready low means no free location; fifo writes are ignored.
// - write pointer advances per word; freed location raises input-ready on second edge.
// - select pair high/low presets offsets to 64, low/high presets them to 8.
// - reset clears pointers, lowers ready and almost-empty, raises almost-full and mail flags.
module dcf_fifo (
    // clock and reset
    input logic mclk,
    input logic reset,
    // offset programming pins
    input logic offset_select0_serial_data,
    input logic offset_select1_serial_enable,
    // port A control
    input logic port_a_select_n,
    input logic port_a_write_not_read,
    input logic port_a_xfer_gate,
    input logic port_a_mailbox_sel,
    // port A bus
    input logic [35:0] port_a_bus_in,
    output logic [35:0] port_a_bus_out,
    output logic port_a_bus_oe,
    // port A flags
    output logic input_ready,
    output logic almost_full_n,
    output logic a_to_b_mail_flag_n,
    // port B control
    input logic port_b_select_n,
    input logic port_b_read_not_write,
    input logic port_b_xfer_gate,
    input logic port_b_mailbox_sel,
    // port B bus
    input logic [35:0] port_b_bus_in,
    output logic [35:0] port_b_bus_out,
    output logic port_b_bus_oe,
    // port B flags
    output logic output_ready,
    output logic almost_empty_n,
    output logic b_to_a_mail_flag_n
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    dcf_pkg::dcf_state_t state_reg;
    dcf_pkg::dcf_mode_t mode_reg;
    logic [10:0] almost_full_offset_reg, almost_empty_offset_reg;
    logic [4:0] ser_cnt_reg;
    logic [35:0] mem [0:2047];
    logic [11:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [11:0] rptr_s1_reg, wptr_s1_reg, wptr_s2_reg;
    logic [11:0] words_a, words_b, af_limit;
    logic ir_reg, ir_next, af_n_reg, or_reg, or_next, ae_n_reg;
    logic [35:0] out_reg, pf_reg, a_to_b_mailbox_reg, b_to_a_mailbox_reg;
    logic pf_valid_reg, a2b_flag_n_reg, b2a_flag_n_reg;
    logic wr_req, mem_wr, a_mail_wr, a_mail_rd, b_mail_wr, b_mail_rd, fifo_rd;
    logic mem_avail, need_head, head_from_pf, head_from_mem, pf_ready, pf_load, ir_state_ok;

    // ---------------------------------------------------------------
    // port decode
    // ---------------------------------------------------------------
    assign wr_req = !port_a_select_n && !port_a_mailbox_sel && port_a_write_not_read
                    && port_a_xfer_gate && ir_reg;
    assign mem_wr = wr_req && (state_reg == dcf_pkg::DCF_ST_RUN);
    assign a_mail_wr = !port_a_select_n && port_a_mailbox_sel && port_a_write_not_read && port_a_xfer_gate;
    assign a_mail_rd = !port_a_select_n && port_a_mailbox_sel && !port_a_write_not_read
                       && port_a_xfer_gate;
    assign b_mail_wr = !port_b_select_n && port_b_mailbox_sel && !port_b_read_not_write && port_b_xfer_gate;
    assign b_mail_rd = !port_b_select_n && port_b_mailbox_sel && port_b_read_not_write
                       && port_b_xfer_gate;
    assign fifo_rd = !port_b_select_n && !port_b_mailbox_sel && port_b_read_not_write
                     && port_b_xfer_gate && or_reg;

    // bus drivers
    assign port_a_bus_oe = !port_a_select_n && !port_a_write_not_read;
    assign port_a_bus_out = b_to_a_mailbox_reg;
    assign port_b_bus_oe = !port_b_select_n && port_b_read_not_write;
    assign port_b_bus_out = port_b_mailbox_sel ? a_to_b_mailbox_reg : out_reg;

    // ---------------------------------------------------------------
    // offset programming sequence
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= dcf_pkg::DCF_ST_IDLE;
            mode_reg <= dcf_pkg::DCF_MODE_PARALLEL;
        end else begin
            case (state_reg)
                dcf_pkg::DCF_ST_IDLE: begin
                    // first edge after release samples the select pair
                    mode_reg <= dcf_pkg::dcf_mode_t'({offset_select1_serial_enable,
                                                      offset_select0_serial_data});
                    state_reg <= dcf_pkg::DCF_ST_WAIT;
                end
                dcf_pkg::DCF_ST_WAIT: begin
                    case (mode_reg)
                        dcf_pkg::DCF_MODE_PARALLEL: state_reg <= dcf_pkg::DCF_ST_PAR_Y;
                        dcf_pkg::DCF_MODE_SERIAL: state_reg <= dcf_pkg::DCF_ST_SERIAL;
                        default: state_reg <= dcf_pkg::DCF_ST_RUN;
                    endcase
                end
                dcf_pkg::DCF_ST_PAR_Y: begin
                    if (wr_req) begin
                        state_reg <= dcf_pkg::DCF_ST_PAR_X;
                    end
                end
                dcf_pkg::DCF_ST_PAR_X: begin
                    if (wr_req) begin
                        state_reg <= dcf_pkg::DCF_ST_RUN;
                    end
                end
                dcf_pkg::DCF_ST_SERIAL: begin
                    if (!offset_select1_serial_enable && ser_cnt_reg == dcf_pkg::SER_LAST) begin
                        state_reg <= dcf_pkg::DCF_ST_SER_DONE;
                    end
                end
                dcf_pkg::DCF_ST_SER_DONE: state_reg <= dcf_pkg::DCF_ST_RUN;
                dcf_pkg::DCF_ST_RUN: state_reg <= dcf_pkg::DCF_ST_RUN;
                default: state_reg <= dcf_pkg::DCF_ST_IDLE;
            endcase
        end
    end

    // serial bit counter
    always_ff @(posedge mclk) begin
        if (reset) begin
            ser_cnt_reg <= 5'h00;
        end else if (state_reg == dcf_pkg::DCF_ST_SERIAL && !offset_select1_serial_enable) begin
            ser_cnt_reg <= ser_cnt_reg + 5'h01;
        end
    end

    // offset registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            almost_full_offset_reg <= dcf_pkg::OFS_RESET;
            almost_empty_offset_reg <= dcf_pkg::OFS_RESET;
        end else if (state_reg == dcf_pkg::DCF_ST_IDLE) begin
            if ({offset_select1_serial_enable, offset_select0_serial_data} == 2'h1) begin
                almost_full_offset_reg <= dcf_pkg::OFS_PRESET_SMALL;
                almost_empty_offset_reg <= dcf_pkg::OFS_PRESET_SMALL;
            end else if ({offset_select1_serial_enable, offset_select0_serial_data} == 2'h2) begin
                almost_full_offset_reg <= dcf_pkg::OFS_PRESET_LARGE;
                almost_empty_offset_reg <= dcf_pkg::OFS_PRESET_LARGE;
            end
        end else if (state_reg == dcf_pkg::DCF_ST_PAR_Y && wr_req) begin
            almost_full_offset_reg <= port_a_bus_in[10:0];
        end else if (state_reg == dcf_pkg::DCF_ST_PAR_X && wr_req) begin
            almost_empty_offset_reg <= port_a_bus_in[10:0];
        end else if (state_reg == dcf_pkg::DCF_ST_SERIAL && !offset_select1_serial_enable) begin
            // almost-full msb enters first, almost-empty lsb last
            {almost_full_offset_reg, almost_empty_offset_reg} <=
                {almost_full_offset_reg[9:0], almost_empty_offset_reg, offset_select0_serial_data};
        end
    end

    // ---------------------------------------------------------------
    // storage array and write side
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (mem_wr) begin
            mem[wptr_reg[10:0]] <= port_a_bus_in;
        end
    end

    assign wptr_next = mem_wr ? wptr_reg + 12'h001 : wptr_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            wptr_reg <= dcf_pkg::PTR_RESET;
        end else begin
            wptr_reg <= wptr_next;
        end
    end

    // read pointer into the write side, second stage is the flag itself
    always_ff @(posedge mclk) begin
        if (reset) begin
            rptr_s1_reg <= dcf_pkg::PTR_RESET;
        end else begin
            rptr_s1_reg <= rptr_reg;
        end
    end

    assign words_a = wptr_next - rptr_s1_reg;
    assign af_limit = dcf_pkg::FIFO_DEPTH - {1'b0, almost_full_offset_reg};
    assign ir_state_ok = (state_reg == dcf_pkg::DCF_ST_WAIT && mode_reg != dcf_pkg::DCF_MODE_SERIAL)
                         || state_reg == dcf_pkg::DCF_ST_PAR_Y || state_reg == dcf_pkg::DCF_ST_PAR_X
                         || state_reg == dcf_pkg::DCF_ST_SER_DONE || state_reg == dcf_pkg::DCF_ST_RUN;
    assign ir_next = ir_state_ok && (words_a != dcf_pkg::FIFO_DEPTH);

    always_ff @(posedge mclk) begin
        if (reset) begin
            ir_reg <= 1'b0;
            af_n_reg <= 1'b1;
        end else begin
            ir_reg <= ir_next;
            af_n_reg <= words_a < af_limit;
        end
    end

    assign input_ready = ir_reg;
    assign almost_full_n = af_n_reg;

    // ---------------------------------------------------------------
    // read side: write pointer stages, prefetch slot, output register
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            wptr_s1_reg <= dcf_pkg::PTR_RESET;
            wptr_s2_reg <= dcf_pkg::PTR_RESET;
        end else begin
            wptr_s1_reg <= wptr_reg;
            wptr_s2_reg <= wptr_s1_reg;
        end
    end

    assign mem_avail = wptr_s2_reg != rptr_reg;
    assign need_head = !or_reg || fifo_rd;
    assign head_from_pf = need_head && pf_valid_reg;
    assign head_from_mem = need_head && !pf_valid_reg && mem_avail;
    assign pf_ready = !pf_valid_reg || head_from_pf;
    assign pf_load = mem_avail && !head_from_mem && pf_ready;
    assign rptr_next = (head_from_mem || pf_load) ? rptr_reg + 12'h001 : rptr_reg;
    assign or_next = need_head ? (pf_valid_reg || mem_avail) : 1'b1;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rptr_reg <= dcf_pkg::PTR_RESET;
        end else begin
            rptr_reg <= rptr_next;
        end
    end

    // one-entry slot in front of the output register absorbs a stalled reader
    always_ff @(posedge mclk) begin
        if (reset) begin
            pf_valid_reg <= 1'b0;
            pf_reg <= dcf_pkg::DATA_RESET;
        end else if (pf_load) begin
            pf_valid_reg <= 1'b1;
            pf_reg <= mem[rptr_reg[10:0]];
        end else if (head_from_pf) begin
            pf_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            out_reg <= dcf_pkg::DATA_RESET;
            or_reg <= 1'b0;
        end else begin
            or_reg <= or_next;
            if (head_from_pf) begin
                out_reg <= pf_reg;
            end else if (head_from_mem) begin
                out_reg <= mem[rptr_reg[10:0]];
            end
        end
    end

    assign words_b = wptr_s2_reg - rptr_reg + {11'h000, pf_valid_reg};

    always_ff @(posedge mclk) begin
        if (reset) begin
            ae_n_reg <= 1'b0;
        end else begin
            ae_n_reg <= words_b > {1'b0, almost_empty_offset_reg};
        end
    end

    assign output_ready = or_reg;
    assign almost_empty_n = ae_n_reg;

    // ---------------------------------------------------------------
    // mailboxes, a new message wins over a same-edge read
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            a_to_b_mailbox_reg <= dcf_pkg::DATA_RESET;
            a2b_flag_n_reg <= 1'b1;
        end else if (a_mail_wr) begin
            a_to_b_mailbox_reg <= port_a_bus_in;
            a2b_flag_n_reg <= 1'b0;
        end else if (b_mail_rd) begin
            a2b_flag_n_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            b_to_a_mailbox_reg <= dcf_pkg::DATA_RESET;
            b2a_flag_n_reg <= 1'b1;
        end else if (b_mail_wr) begin
            b_to_a_mailbox_reg <= port_b_bus_in;
            b2a_flag_n_reg <= 1'b0;
        end else if (a_mail_rd) begin
            b2a_flag_n_reg <= 1'b1;
        end
    end

    assign a_to_b_mail_flag_n = a2b_flag_n_reg;
    assign b_to_a_mail_flag_n = b2a_flag_n_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_par_ir_rise: assert property (
        ($past(reset) && !reset && !offset_select0_serial_data && !offset_select1_serial_enable)
        |-> ##1 !input_ready ##1 input_ready)
        else $error("input ready did not rise two edges after parallel reset");

    a_preset_eight: assert property (
        ($past(reset) && !reset && offset_select0_serial_data && !offset_select1_serial_enable)
        |=> (almost_full_offset_reg == 11'h008 && almost_empty_offset_reg == 11'h008))
        else $error("preset of eight not loaded");

    a_par_offset_load: assert property (
        (state_reg == dcf_pkg::DCF_ST_PAR_Y && wr_req)
        |=> (almost_full_offset_reg == $past(port_a_bus_in[10:0]) && wptr_reg == $past(wptr_reg)))
        else $error("first parallel write did not load the almost-full offset");

    a_serial_ir_low: assert property (
        (state_reg == dcf_pkg::DCF_ST_SERIAL) |-> !input_ready)
        else $error("input ready high during serial loading");

    a_serial_ir_rise: assert property (
        (state_reg == dcf_pkg::DCF_ST_SER_DONE && wptr_reg == rptr_s1_reg) |=> input_ready)
        else $error("input ready not set after last serial bit");

    a_write_store: assert property (
        mem_wr |=> wptr_reg == $past(wptr_reg) + 12'h001)
        else $error("write pointer did not advance on a stored word");

    a_write_ignored: assert property (
        !input_ready |=> wptr_reg == $past(wptr_reg))
        else $error("write accepted while input ready low");

    a_or_latency: assert property (
        (mem_wr && wptr_reg == rptr_reg && wptr_s2_reg == rptr_reg && !output_ready && !pf_valid_reg)
        |-> ##3 !output_ready ##1 output_ready)
        else $error("new word not shown on third read-side edge");

    a_or_hold: assert property (
        (!output_ready && !mem_avail) |=> $stable(out_reg))
        else $error("output register changed while output ready low");

    a_mail_b_read: assert property (
        (b_mail_rd && !a_mail_wr) |=> a_to_b_mail_flag_n)
        else $error("port B mailbox read did not raise its flag");

    a_mail_a_read: assert property (
        (a_mail_rd && !b_mail_wr) |=> b_to_a_mail_flag_n)
        else $error("port A mailbox read did not raise its flag");

    a_reset_flags: assert property (@(posedge mclk) disable iff (1'b0)
        reset |=> (!input_ready && !output_ready && !almost_empty_n && almost_full_n
                   && a_to_b_mail_flag_n && b_to_a_mail_flag_n && wptr_reg == 12'h000))
        else $error("reset did not set flags and pointers");

    c_serial_done: cover property (state_reg == dcf_pkg::DCF_ST_SER_DONE);
    c_par_done: cover property (state_reg == dcf_pkg::DCF_ST_PAR_X && wr_req);
    c_or_rise: cover property (!output_ready ##1 output_ready);
    c_fifo_full: cover property (input_ready ##1 !input_ready && state_reg == dcf_pkg::DCF_ST_RUN);
    c_slot_stall: cover property (pf_valid_reg && output_ready && !fifo_rd);

endmodule

// ### test/dcf_b_reader.sv
// port B reader model with random stalls and mailbox reads
`timescale 1ns/100ps
module dcf_b_reader (
    // clock
    input logic mclk,
    // bench control
    input logic hold,
    input logic mbox,
    input logic bwr,
    // port B
    input logic output_ready,
    input logic [35:0] port_b_bus_out,
    output logic port_b_select_n,
    output logic port_b_read_not_write,
    output logic port_b_xfer_gate,
    output logic port_b_mailbox_sel
);
    logic [35:0] got_q[$];
    int seed = 89;
    initial begin
        port_b_select_n = 1'b0;
        port_b_read_not_write = 1'b1;
        port_b_xfer_gate = 1'b0;
        port_b_mailbox_sel = 1'b0;
    end
    // the word a taken fifo read consumes
    always @(posedge mclk) begin
        if (port_b_xfer_gate && !port_b_mailbox_sel && output_ready) got_q.push_back(port_b_bus_out);
    end
    // requests change only after the falling edge
    always @(negedge mclk) begin
        port_b_mailbox_sel <= mbox;
        port_b_read_not_write <= !bwr;
        port_b_xfer_gate <= mbox || (!hold && $random(seed) % 2 != 0);
    end
endmodule

// ### test/tb_dual_clock_fifo_port_flags.sv
// self-checking bench for the dual-port fifo with port flags
`timescale 1ns/100ps
module tb_dual_clock_fifo_port_flags;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic offset_select0_serial_data = 1'b0;
    logic offset_select1_serial_enable = 1'b0;
    logic port_a_select_n = 1'b1;
    logic port_a_write_not_read = 1'b1;
    logic port_a_xfer_gate = 1'b0;
    logic port_a_mailbox_sel = 1'b0;
    logic [35:0] port_a_bus_in = 36'h000000000;
    logic hold = 1'b1;
    logic mbox = 1'b0;
    logic bwr = 1'b0;
    logic [35:0] port_b_bus_in = 36'h000000000;
    logic [35:0] port_a_bus_out, port_b_bus_out;
    logic port_a_bus_oe, port_b_bus_oe, input_ready, almost_full_n, almost_empty_n, output_ready;
    logic a_to_b_mail_flag_n, b_to_a_mail_flag_n;
    logic port_b_select_n, port_b_read_not_write, port_b_xfer_gate, port_b_mailbox_sel;
    logic [35:0] exp_q[$];
    logic [10:0] ofs_x[4] = '{11'h002, 11'h008, 11'h040, 11'h003};
    int seed = 89;
    int miscompares = 0;
    int checked = 0;
    always #12.5 mclk = ~mclk;
    dcf_fifo dut_u (.mclk, .reset, .offset_select0_serial_data, .offset_select1_serial_enable,
        .port_a_select_n, .port_a_write_not_read, .port_a_xfer_gate, .port_a_mailbox_sel,
        .port_a_bus_in, .port_a_bus_out, .port_a_bus_oe, .input_ready, .almost_full_n,
        .a_to_b_mail_flag_n, .port_b_select_n, .port_b_read_not_write, .port_b_xfer_gate,
        .port_b_mailbox_sel, .port_b_bus_in, .port_b_bus_out, .port_b_bus_oe,
        .output_ready, .almost_empty_n, .b_to_a_mail_flag_n);
    dcf_b_reader rd_u (.mclk, .hold, .mbox, .bwr, .output_ready, .port_b_bus_out, .port_b_select_n,
        .port_b_read_not_write, .port_b_xfer_gate, .port_b_mailbox_sel);
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [35:0] d, input logic mb, input logic keep);
        @(negedge mclk);
        port_a_select_n = 1'b0;
        port_a_write_not_read = 1'b1;
        port_a_xfer_gate = 1'b1;
        port_a_mailbox_sel = mb;
        port_a_bus_in = d;
        if (keep && input_ready === 1'b1) exp_q.push_back(d);
    endtask
    task automatic idle(input int n);
        @(negedge mclk);
        port_a_xfer_gate = 1'b0;
        port_a_write_not_read = 1'b0;
        repeat (n) @(negedge mclk);
    endtask
    task automatic rst(input logic [1:0] sel);
        @(negedge mclk);
        reset = 1'b1;
        {offset_select1_serial_enable, offset_select0_serial_data} = sel;
        exp_q.delete();
        repeat (2) @(negedge mclk);
        chk({input_ready, output_ready, almost_empty_n, almost_full_n, a_to_b_mail_flag_n,
            b_to_a_mail_flag_n} === 6'h07, "reset flags");
        rd_u.got_q.delete();
        reset = 1'b0;
        @(negedge mclk);
        chk(input_ready === 1'b0, "ready early");
        @(negedge mclk);
        chk(input_ready === (sel != 2'h3), "ready after reset");
    endtask
    task automatic ser(input logic [21:0] bits);
        for (int k = 21; k >= 0; k--) begin
            @(negedge mclk);
            offset_select1_serial_enable = 1'b0;
            offset_select0_serial_data = bits[k];
        end
        @(negedge mclk);
        offset_select1_serial_enable = 1'b1;
        chk(input_ready === 1'b0, "serial early");
        @(negedge mclk);
        chk(input_ready === 1'b1, "serial done");
    endtask
    task automatic ae_chk(input int n, input logic e);
        repeat (n) wr(36'({$random(seed), $random(seed)}), 1'b0, 1'b1);
        idle(8);
        chk(almost_empty_n === e, "almost-empty level");
    endtask
    task automatic drain();
        int i;
        hold = 1'b0;
        for (i = 0; i < 8000 && rd_u.got_q.size() < exp_q.size(); i++) @(negedge mclk);
        chk(rd_u.got_q.size() == exp_q.size(), "drain count");
        if (i >= 8000) stop_test();
        for (i = 0; i < exp_q.size(); i++) chk(rd_u.got_q[i] === exp_q[i], "data order");
        idle(4);
        chk(output_ready === 1'b0, "empty after drain");
        rd_u.got_q.delete();
        exp_q.delete();
        hold = 1'b1;
    endtask
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        int m;
        for (m = 0; m < 4; m++) begin
            rst(m[1:0]);
            if (m == 0) wr(36'h000000005, 1'b0, 1'b0);
            if (m == 0) wr({25'h0, ofs_x[0]}, 1'b0, 1'b0);
            if (m == 3) ser({11'h005, ofs_x[3]});
            ae_chk(ofs_x[m] + 1, 1'b0);
            chk(output_ready === 1'b1 && port_b_bus_oe === 1'b1 && port_a_bus_oe === 1'b1, "oe");
            chk(port_b_bus_out === exp_q[0], "head word");
            ae_chk(1, 1'b1);
            drain();
        end
        wr(36'h0A5A5A5A5, 1'b1, 1'b0);
        idle(1);
        chk(a_to_b_mail_flag_n === 1'b0, "mail flag low");
        mbox = 1'b1;
        repeat (3) @(negedge mclk);
        chk(port_b_bus_out === 36'h0A5A5A5A5 && a_to_b_mail_flag_n === 1'b1, "mail read");
        bwr = 1'b1;
        port_b_bus_in = 36'({$random(seed), $random(seed)});
        repeat (3) @(negedge mclk);
        chk(b_to_a_mail_flag_n === 1'b0 && port_a_bus_out === port_b_bus_in && port_b_bus_oe === 1'b0,
            "mail back");
        bwr = 1'b0;
        mbox = 1'b0;
        @(negedge mclk);
        port_a_write_not_read = 1'b0;
        port_a_xfer_gate = 1'b1;
        idle(1);
        chk(b_to_a_mail_flag_n === 1'b1 && port_a_bus_oe === 1'b1, "mail back read");
        for (m = 0; m < 2100 && input_ready !== 1'b0; m++) wr(36'(m), 1'b0, 1'b1);
        wr(36'h0FFFFFFFF, 1'b0, 1'b1);
        idle(2);
        chk(input_ready === 1'b0 && almost_full_n === 1'b0 && m < 2100, "full flags");
        drain();
        stop_test();
    end
endmodule
